// file: host_model.sv
// Purpose: Host master that sets up and reads back the planner
// Assumes: Slave answers by waitrequest low for one cycle
// Notes:   Request held until waitrequest sampled low
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        i_clk,
  // Avalon-MM master
  output logic      [7:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest
);
  initial begin
    o_address   = 8'h00;
    o_read      = 1'b0;
    o_write     = 1'b0;
    o_writedata = 32'h0;
  end

  // One transfer; request held until waitrequest sampled low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_address   <= a;
    o_writedata <= d;
    o_read      <= !wr;
    o_write     <= wr;
    @(posedge i_clk);
    while (i_waitrequest) @(posedge i_clk);
    q = i_readdata;
    o_read      <= 1'b0;
    o_write     <= 1'b0;
    o_writedata <= ~d;
  endtask
endmodule // host_model

// file: scope_rate_cfg.svh
// Purpose: Offsets, field positions, reset values and constants of the scope rate planner
// Assumes: Included by its bare name from the planner and the testbench
// Notes:   Operation list follows
//
// Operation
// - Twenty samples are stored for every division of the sweep step time.
// - Group prescale is 1 without filter, 2 above 10 kHz, 30 otherwise.
// - Largest prescale of all groups is applied.
// - Converter speed is 3 MS/s divided by the applied prescale.
// - Buffer depth is the constant 1048576 samples, also in master-slave.
// - Channel count is the largest channel number of any single instrument.
// - Pack factor is 50, 20, 10, 5, 2 or 1; defaults to 10. Here a held pack can be any integer from 1 to 50.
// - Interface transfer delivers every stored value whatever the pack factor.
// - While held, storage speed stays fixed; sweep changes alter pack only.
// - Storage speed is twenty times pack factor over sweep step time.
// - Capture span is buffer depth over channel count over storage speed.
// - Ceiling is buffer depth over cycle time times channels times 1.7.
// - Ceiling above converter speed is clamped to converter speed.
// - Sweep floor is twenty over ceiling; smaller sweep steps are refused.
// - Non-integer converter-to-storage ratio is floored and divides converter speed.
// - Unheld pack: 10 at ratio 10+, 5 from 5, 2 from 2, else 1.
// - On hold save sweep and pack; pack becomes new sweep times ratio, 1-50.
// - Pack factor outside 1 to 50 marks the sweep setting invalid.
`ifndef SCOPE_RATE_CFG_SVH
`define SCOPE_RATE_CFG_SVH

`define REG_CTRL         8'h00
`define REG_FILTER       8'h04
`define REG_CYCLE        8'h08
`define REG_CHANNELS     8'h0c
`define REG_STATUS       8'h10
`define REG_SPEED        8'h14
`define REG_PACK         8'h18
`define REG_SPAN         8'h1c
`define REG_CEILING      8'h20
`define REG_FLOOR        8'h24
`define REG_CONV         8'h28

`define CTRL_FREEZE_BIT  4
`define STEP_COUNT       5'd16
`define SAMPLES_PER_DIV  48'd20
`define BUF_DEPTH        48'd1048576
`define SWEEP_STEP_TIME_RATE        48'd3000000
`define ADMIN_X10        48'd17
`define US_PER_S         48'd1000000
`define MS_PER_S         48'd1000
`define PRESC_NONE       48'd1
`define PRESC_HIGH       48'd2
`define PRESC_LOW        48'd30
`define PACK_RESET       8'd10
`define PACK_MAX         48'd50
`define STEP_RESET       4'd9
`define CYCLE_RESET      16'd500
`define CHAN_RESET       4'h4
`define DIV_BITS         6'd48

`endif

// file: scope_rate_pkg.sv
// Purpose: Types of the scope rate planner
// Assumes: Constants come from the cfg header
// Notes:   Nothing is imported; users write scope_rate_pkg::name
package scope_rate_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_DIV   = 4'b0100,
    ST_STORE = 4'b1000
  } state_t;

  typedef enum logic [2:0] {
    PH_CONV  = 3'h0,
    PH_CEIL  = 3'h1,
    PH_FLOOR = 3'h2,
    PH_PACK  = 3'h3,
    PH_RATE  = 3'h4,
    PH_RATIO = 3'h5,
    PH_REAL  = 3'h6,
    PH_SPAN  = 3'h7
  } phase_t;

  typedef struct packed {
    logic [3:0]  step;
    logic        freeze;
    logic [15:0] filters;
    logic [15:0] cycle_ms;
    logic [3:0]  chan_master;
    logic [3:0]  chan_slave;
  } cfg_t;

  typedef struct packed {
    logic [31:0] speed;
    logic [7:0]  pack;
    logic [31:0] span_ms;
    logic [31:0] ceiling;
    logic [31:0] floor_us;
    logic [31:0] conv;
  } result_t;

endpackage

// file: scope_rate_planner.sv
// Purpose: Scope storage rate, pack factor, span and limits from host settings
// Assumes: Avalon-MM slave with waitrequest; one clock, synchronous active-low reset
// Notes:   One shared serial divider runs each computation phase in turn
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "scope_rate_cfg.svh"

module scope_rate_planner #(
  parameter int GROUPS = 3
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Avalon-MM slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Status
  output logic             o_busy,
  output logic             o_error
);

  if (GROUPS < 1 || GROUPS > 8) begin : g_groups_check
    $error("GROUPS must be 1 to 8");
  end

  scope_rate_pkg::cfg_t    cfg_r;
  scope_rate_pkg::result_t res_r;
  scope_rate_pkg::state_t  state_r;
  scope_rate_pkg::phase_t  phase_r;
  logic [3:0]  saved_sweep_step_r;
  logic [7:0]  saved_pack_factor_r;
  logic [31:0] rate_req_r;
  logic [31:0] ratio_r;
  logic        start_r;
  logic        wr_go;
  logic [47:0] num_r;
  logic [47:0] den_r;
  logic [47:0] quo_r;
  logic [48:0] rem_r;
  logic [5:0]  cnt_r;
  logic [48:0] rem_shift;
  logic [47:0] step_us;
  logic [47:0] presc;
  logic [47:0] chan;

  // Sweep step in microseconds from its 1-2-5 index
  function automatic logic [47:0] step_to_us(input logic [3:0] idx);
    logic [47:0] dec;
    logic [47:0] mant;
    dec = 48'd10;
    for (int i = 0; i < 5; i++) begin
      if (idx >= 4'(3 * (i + 1))) begin
        dec = dec * 48'd10;
      end
    end
    case (idx % 4'd3)
      4'd0:    mant = 48'd1;
      4'd1:    mant = 48'd2;
      default: mant = 48'd5;
    endcase
    step_to_us = dec * mant;
  endfunction

  // Largest prescale over all groups
  function automatic logic [47:0] max_presc(input logic [15:0] f);
    logic [47:0] m;
    m = `PRESC_NONE;
    for (int g = 0; g < GROUPS; g++) begin
      if (f[2*g +: 2] == 2'h1 && m < `PRESC_HIGH) begin
        m = `PRESC_HIGH;
      end else if (f[2*g +: 2] >= 2'h2) begin
        m = `PRESC_LOW;
      end
    end
    max_presc = m;
  endfunction

  // Channel count is the larger instrument
  function automatic logic [47:0] max_chan(input logic [3:0] a, input logic [3:0] b);
    max_chan = {44'h0, (a > b) ? a : b};
  endfunction

  always_comb begin
    step_us   = step_to_us(cfg_r.step);
    presc     = max_presc(cfg_r.filters);
    chan      = max_chan(cfg_r.chan_master, cfg_r.chan_slave);
    rem_shift = {rem_r[47:0], num_r[47]};
  end

  assign wr_go = i_write && !o_waitrequest;

  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0;
    end else if ((i_read || i_write) && o_waitrequest) begin
      o_waitrequest <= 1'b0;
      o_readdata    <= 32'h0;
      if (i_read) begin
        case (i_address)
          `REG_CTRL:     o_readdata <= {27'h0, cfg_r.freeze, cfg_r.step};
          `REG_FILTER:   o_readdata <= {16'h0, cfg_r.filters};
          `REG_CYCLE:    o_readdata <= {16'h0, cfg_r.cycle_ms};
          `REG_CHANNELS: o_readdata <= {24'h0, cfg_r.chan_slave, cfg_r.chan_master};
          `REG_STATUS:   o_readdata <= {30'h0, o_error, o_busy};
          `REG_SPEED:    o_readdata <= res_r.speed;
          `REG_PACK:     o_readdata <= {24'h0, res_r.pack};
          `REG_SPAN:     o_readdata <= res_r.span_ms;
          `REG_CEILING:  o_readdata <= res_r.ceiling;
          `REG_FLOOR:    o_readdata <= res_r.floor_us;
          `REG_CONV:     o_readdata <= res_r.conv;
          default:       o_readdata <= 32'h0;
        endcase
      end
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg_r.step        <= `STEP_RESET;
      cfg_r.freeze      <= 1'b0;
      cfg_r.filters     <= 16'h0;
      cfg_r.cycle_ms    <= `CYCLE_RESET;
      cfg_r.chan_master <= `CHAN_RESET;
      cfg_r.chan_slave  <= 4'h0;
    end else if (wr_go) begin
      case (i_address)
        `REG_CTRL: begin
          if (i_writedata[3:0] < `STEP_COUNT) begin
            cfg_r.step <= i_writedata[3:0];
          end
          cfg_r.freeze <= i_writedata[`CTRL_FREEZE_BIT];
        end
        `REG_FILTER:   cfg_r.filters     <= i_writedata[15:0];
        `REG_CYCLE:    cfg_r.cycle_ms    <= i_writedata[15:0];
        `REG_CHANNELS: begin
          cfg_r.chan_master <= i_writedata[3:0];
          cfg_r.chan_slave  <= i_writedata[7:4];
        end
        default: ;
      endcase
    end
  end

  // Hold snapshot of sweep and pack
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      saved_sweep_step_r  <= `STEP_RESET;
      saved_pack_factor_r <= `PACK_RESET;
    end else if (wr_go && i_address == `REG_CTRL && i_writedata[`CTRL_FREEZE_BIT] && !cfg_r.freeze) begin
      saved_sweep_step_r  <= cfg_r.step;
      saved_pack_factor_r <= res_r.pack;
    end
  end

  // Recompute request; a new write wins over the start taken
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      start_r <= 1'b1;
    end else if (wr_go && i_address <= `REG_CHANNELS) begin
      start_r <= 1'b1;
    end else if (state_r == scope_rate_pkg::ST_IDLE) begin
      start_r <= 1'b0;
    end
  end

  // Serial restoring divider
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rem_r <= 49'h0;
      quo_r <= 48'h0;
      cnt_r <= 6'h0;
    end else if (state_r == scope_rate_pkg::ST_LOAD) begin
      rem_r <= 49'h0;
      quo_r <= 48'h0;
      cnt_r <= `DIV_BITS;
    end else if (state_r == scope_rate_pkg::ST_DIV) begin
      cnt_r <= cnt_r - 6'd1;
      if (rem_shift >= {1'b0, den_r}) begin
        rem_r <= rem_shift - {1'b0, den_r};
        quo_r <= {quo_r[46:0], 1'b1};
      end else begin
        rem_r <= rem_shift;
        quo_r <= {quo_r[46:0], 1'b0};
      end
    end
  end

  // Operand selection and dividend shifting
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      num_r <= 48'h0;
      den_r <= 48'h1;
    end else if (state_r == scope_rate_pkg::ST_LOAD) begin
      case (phase_r)
        scope_rate_pkg::PH_CONV: begin
          num_r <= `SWEEP_STEP_TIME_RATE;
          den_r <= presc;
        end
        scope_rate_pkg::PH_CEIL: begin
          num_r <= `BUF_DEPTH * 48'd10 * `MS_PER_S;
          den_r <= {32'h0, cfg_r.cycle_ms} * `ADMIN_X10 * chan;
        end
        scope_rate_pkg::PH_FLOOR: begin
          num_r <= `SAMPLES_PER_DIV * `US_PER_S;
          den_r <= {16'h0, res_r.ceiling};
        end
        scope_rate_pkg::PH_PACK: begin
          if (cfg_r.freeze) begin
            num_r <= step_us * {40'h0, saved_pack_factor_r};
            den_r <= step_to_us(saved_sweep_step_r);
          end else begin
            num_r <= {16'h0, res_r.ceiling} * step_us;
            den_r <= `SAMPLES_PER_DIV * `US_PER_S;
          end
        end
        scope_rate_pkg::PH_RATE: begin
          num_r <= `SAMPLES_PER_DIV * `US_PER_S * {40'h0, res_r.pack};
          den_r <= step_us;
        end
        scope_rate_pkg::PH_RATIO: begin
          num_r <= {16'h0, res_r.conv};
          den_r <= {16'h0, rate_req_r};
        end
        scope_rate_pkg::PH_REAL: begin
          num_r <= {16'h0, res_r.conv};
          den_r <= {16'h0, ratio_r};
        end
        default: begin
          num_r <= `BUF_DEPTH * `MS_PER_S;
          den_r <= chan * {16'h0, res_r.speed};
        end
      endcase
    end else if (state_r == scope_rate_pkg::ST_DIV) begin
      num_r <= {num_r[46:0], 1'b0};
    end
  end

  // Phase sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= scope_rate_pkg::ST_IDLE;
      phase_r <= scope_rate_pkg::PH_CONV;
      o_busy  <= 1'b0;
    end else begin
      case (state_r)
        scope_rate_pkg::ST_IDLE: begin
          o_busy <= start_r;
          if (start_r) begin
            phase_r <= scope_rate_pkg::PH_CONV;
            state_r <= scope_rate_pkg::ST_LOAD;
          end
        end
        scope_rate_pkg::ST_LOAD: begin
          if (cfg_r.cycle_ms == 16'h0 || chan == 48'h0) begin
            state_r <= scope_rate_pkg::ST_IDLE;
          end else begin
            state_r <= scope_rate_pkg::ST_DIV;
          end
        end
        scope_rate_pkg::ST_DIV: begin
          if (cnt_r == 6'd1) begin
            state_r <= scope_rate_pkg::ST_STORE;
          end
        end
        scope_rate_pkg::ST_STORE: begin
          state_r <= scope_rate_pkg::ST_LOAD;
          phase_r <= scope_rate_pkg::phase_t'(phase_r + 3'h1);
          case (phase_r)
            scope_rate_pkg::PH_FLOOR: begin
              if (step_us < quo_r) begin
                state_r <= scope_rate_pkg::ST_IDLE;
              end
            end
            scope_rate_pkg::PH_PACK: begin
              if (cfg_r.freeze) begin
                state_r <= scope_rate_pkg::ST_IDLE;
              end
            end
            scope_rate_pkg::PH_SPAN: state_r <= scope_rate_pkg::ST_IDLE;
            default: ;
          endcase
        end
        default: state_r <= scope_rate_pkg::ST_IDLE;
      endcase
    end
  end

  // Results and validity
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      res_r.speed    <= 32'h0;
      res_r.pack     <= `PACK_RESET;
      res_r.span_ms  <= 32'h0;
      res_r.ceiling  <= 32'h0;
      res_r.floor_us <= 32'h0;
      res_r.conv     <= 32'h0;
      rate_req_r     <= 32'h1;
      ratio_r        <= 32'h1;
      o_error        <= 1'b0;
    end else if (state_r == scope_rate_pkg::ST_LOAD && (cfg_r.cycle_ms == 16'h0 || chan == 48'h0)) begin
      o_error <= 1'b1;
    end else if (state_r == scope_rate_pkg::ST_STORE) begin
      case (phase_r)
        scope_rate_pkg::PH_CONV: res_r.conv <= quo_r[31:0];
        scope_rate_pkg::PH_CEIL: begin
          if (quo_r > {16'h0, res_r.conv}) begin
            res_r.ceiling <= res_r.conv;
          end else begin
            res_r.ceiling <= quo_r[31:0];
          end
        end
        scope_rate_pkg::PH_FLOOR: begin
          res_r.floor_us <= quo_r[31:0];
          if (step_us < quo_r) begin
            o_error <= 1'b1;
          end
        end
        scope_rate_pkg::PH_PACK: begin
          if (cfg_r.freeze) begin
            if (quo_r < 48'h1 || quo_r > `PACK_MAX) begin
              o_error <= 1'b1;
            end else begin
              res_r.pack <= quo_r[7:0];
              o_error    <= 1'b0;
            end
          end else if (quo_r >= 48'd10) begin
            res_r.pack <= 8'd10;
          end else if (quo_r >= 48'd5) begin
            res_r.pack <= 8'd5;
          end else if (quo_r >= 48'd2) begin
            res_r.pack <= 8'd2;
          end else begin
            res_r.pack <= 8'd1;
          end
        end
        scope_rate_pkg::PH_RATE: rate_req_r <= (quo_r == 48'h0) ? 32'h1 : quo_r[31:0];
        scope_rate_pkg::PH_RATIO: ratio_r <= (quo_r == 48'h0) ? 32'h1 : quo_r[31:0];
        scope_rate_pkg::PH_REAL: res_r.speed <= quo_r[31:0];
        default: begin
          res_r.span_ms <= quo_r[31:0];
          o_error       <= 1'b0;
        end
      endcase
    end
  end

endmodule // scope_rate_planner

// file: scope_rate_planner_props.sv
// Purpose: Port-level checks of the scope rate planner
// Assumes: Bound to every scope_rate_planner instance
// Notes:   Master holds address until the answer edge
`timescale 1ns/1ps
module scope_rate_props #(
  parameter int GROUPS = 3
) (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        o_busy,
  input wire logic        o_error
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_rd(a);
    !o_waitrequest && i_read && (i_address == a);
  endsequence

  chk_one_wait: assert property (s_req |=> !o_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_answer_once: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer held longer than one cycle");
  chk_answer_needs_req: assert property (!o_waitrequest |-> $past(i_read || i_write))
    else $error("answer without a request");
  chk_unmapped_zero: assert property (!o_waitrequest && i_read && (i_address > 8'h28) |-> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_status_upper: assert property (s_rd(8'h10) |-> o_readdata[31:2] == 30'h0)
    else $error("status upper bits set");
  chk_pack_range: assert property (s_rd(8'h18) |-> o_readdata inside {[32'h1:32'h32]})
    else $error("pack factor outside 1 to 50");
  chk_conv_set: assert property (s_rd(8'h28) |-> o_readdata inside {32'h2dc6c0, 32'h16e360, 32'h186a0})
    else $error("converter speed not a prescaled sweep_step_time rate");
  chk_cfg_busy: assert property (i_write && !o_waitrequest && (i_address <= 8'h0c) |-> ##[1:3] o_busy)
    else $error("config write did not start a recompute");
  chk_busy_ends: assert property ($rose(o_busy) |-> ##[1:1000] !o_busy)
    else $error("recompute did not finish");
  chk_error_quiet: assert property (!o_busy && !$past(o_busy) && !$past(i_write) && !$past(i_write, 2)
                                    |-> $stable(o_error))
    else $error("error flag moved while idle");
endmodule // scope_rate_props

bind scope_rate_planner scope_rate_props #(.GROUPS(GROUPS)) i_props (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_busy(o_busy), .o_error(o_error)
);

// file: testbench.sv
// Purpose: Self-checking bench of the scope rate planner
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes:   Expected figures worked out by hand from the rate rules
`timescale 1ns/1ps
`include "scope_rate_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        busy;
  logic        error;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #2.5 i_clk = ~i_clk;

  host_model i_host (.i_clk(i_clk), .o_address(address), .o_read(read), .o_write(write),
                     .o_writedata(writedata), .i_readdata(readdata), .i_waitrequest(waitrequest));
  scope_rate_planner #(.GROUPS(3)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_address(address),
    .i_read(read), .i_write(write), .i_writedata(writedata), .o_readdata(readdata),
    .o_waitrequest(waitrequest), .o_busy(busy), .o_error(error));

  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic settle();
    logic [31:0] q;
    repeat (4) @(posedge i_clk);
    q = 32'h1;
    for (int i = 0; i < 400 && q[0] !== 1'b0; i++) i_host.xfer(1'b0, `REG_STATUS, 32'h0, q);
  endtask
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    settle();
  endtask
  task automatic results(input logic [31:0] s, p, sp, c, f, v);
    expect_rd(`REG_SPEED, s);
    expect_rd(`REG_PACK, p);
    expect_rd(`REG_SPAN, sp);
    expect_rd(`REG_CEILING, c);
    expect_rd(`REG_FLOOR, f);
    expect_rd(`REG_CONV, v);
  endtask

  task automatic t_defaults();
    settle();
    results(32'h4e20, 32'ha, 32'h3333, 32'h4b4b4, 32'h40, 32'h2dc6c0);
    expect_rd(`REG_STATUS, 32'h0);
    wr(8'h3c, 32'hffffffff);
    expect_rd(8'h3c, 32'h0);
    wr(`REG_STATUS, 32'h3);
    expect_rd(`REG_STATUS, 32'h0);
  endtask

  task automatic t_limits();
    cfg(`REG_CHANNELS, 32'h43);
    expect_rd(`REG_CEILING, 32'h4b4b4);
    cfg(`REG_CHANNELS, 32'h32);
    expect_rd(`REG_CEILING, 32'h64646);
    cfg(`REG_CHANNELS, 32'h00);
    expect_rd(`REG_STATUS, 32'h2);
    cfg(`REG_CHANNELS, 32'h04);
    cfg(`REG_CYCLE, 32'h32);
    expect_rd(`REG_CEILING, 32'h2dc6c0);
    expect_rd(`REG_FLOOR, 32'h6);
    cfg(`REG_CYCLE, 32'h1f4);
  endtask

  task automatic t_bands();
    logic [3:0] idx [4] = '{4'h3, 4'h4, 4'h5, 4'h6};
    logic [7:0] pk [4]  = '{8'h1, 8'h2, 8'h5, 8'ha};
    for (int k = 0; k < 4; k++) begin
      cfg(`REG_CTRL, {28'h0, idx[k]});
      results(32'h30d40, {24'h0, pk[k]}, 32'h51e, 32'h4b4b4, 32'h40, 32'h2dc6c0);
    end
    cfg(`REG_CTRL, 32'h2);
    expect_rd(`REG_STATUS, 32'h2);
    `CHK(error, 1'b1)
    expect_rd(`REG_SPEED, 32'h30d40);
  endtask

  task automatic t_filters();
    cfg(`REG_FILTER, 32'h24);
    cfg(`REG_CTRL, 32'h6);
    results(32'h186a0, 32'h5, 32'ha3d, 32'h186a0, 32'hc8, 32'h186a0);
    cfg(`REG_CTRL, 32'h5);
    results(32'h186a0, 32'h2, 32'ha3d, 32'h186a0, 32'hc8, 32'h186a0);
    cfg(`REG_FILTER, 32'h15);
    expect_rd(`REG_CONV, 32'h16e360);
    expect_rd(`REG_SPEED, 32'h3450d);
    cfg(`REG_FILTER, 32'h0);
  endtask

  task automatic t_freeze();
    cfg(`REG_CTRL, 32'h9);
    cfg(`REG_CTRL, 32'h19);
    cfg(`REG_CTRL, 32'h1a);
    expect_rd(`REG_PACK, 32'h14);
    expect_rd(`REG_SPEED, 32'h4e20);
    cfg(`REG_CTRL, 32'h1f);
    expect_rd(`REG_STATUS, 32'h2);
    expect_rd(`REG_PACK, 32'h14);
    cfg(`REG_CTRL, 32'h18);
    expect_rd(`REG_PACK, 32'h5);
    expect_rd(`REG_STATUS, 32'h0);
    cfg(`REG_CTRL, 32'h13);
    expect_rd(`REG_STATUS, 32'h2);
    expect_rd(`REG_SPEED, 32'h4e20);
    cfg(`REG_CTRL, 32'h9);
    expect_rd(`REG_PACK, 32'ha);
    expect_rd(`REG_STATUS, 32'h0);
  endtask

  task automatic t_reset();
    wr(`REG_CHANNELS, 32'h32);
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK(waitrequest, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(error, 1'b0)
    i_nrst <= 1'b1;
    settle();
    results(32'h4e20, 32'ha, 32'h3333, 32'h4b4b4, 32'h40, 32'h2dc6c0);
    expect_rd(`REG_CHANNELS, 32'h4);
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_defaults();
    t_limits();
    t_bands();
    t_filters();
    t_freeze();
    t_reset();
    final_report();
  end
endmodule // testbench
